/* verilog/srpc_consts.svh */
// Numeric constants for the serial register port and its read checksum.
`ifndef SRPC_CONSTS_SVH
`define SRPC_CONSTS_SVH

`define SRPC_CMD_LAST        5'h07
`define SRPC_DIR_BIT         7
`define SRPC_ADDR_MSB        5
`define SRPC_BYTE_LAST       3'h7
`define SRPC_CNT_ZERO        5'h00
`define SRPC_CNT_ONE         5'h01
`define SRPC_BYTE_ZERO       2'h0
`define SRPC_BYTE_ONE        2'h1
`define SRPC_BYTE_TWO        2'h2
`define SRPC_BYTES_MAX       2'h3
`define SRPC_WORD_BITS       24
`define SRPC_WORD_MSB        23
`define SRPC_CSUM_ZERO       6'h00
`define SRPC_CSUM_ADDR       6'h3f
`define SRPC_BYTE_SPACING_NS 1000

`endif

/* verilog/srpc_pkg.sv */
// Types shared by the serial register port.
package srpc_pkg;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_WRITE,
    PH_READ
  } srpc_phase_type;

  // One received write byte with its destination and byte lane.
  typedef struct packed {
    logic [5:0] addr;
    logic [1:0] lane;
    logic [7:0] data;
  } srpc_wbeat_type;

endpackage

/* verilog/srpc_port.sv */
// Serial register port with command decode, byte write hand-over and read checksum.
//
// Behaviour
// - Input bits sampled on falling serial clock, output bits changed on rising.
// - Each read data bit is driven on a rising serial clock edge.
// - Chip select falling resets the port into command-waiting mode.
// - Chip select rising aborts the transfer and releases the serial output.
// - First byte after reset or chip select falling is the command byte.
// - Command byte is 8 bits: top bit direction, six low bits register address.
// - After each completed data transfer the port awaits a new command byte.
// - A transfer completes once the register's least significant bit has moved.
// - Command top bit 1 selects write; data shifts in from next falling edge.
// - Write bits shift in on each later falling edge until register is filled.
// - Write data moves to its register one byte at a time after each byte.
// - A partly received write byte aborted by chip select is discarded.
// - Registers are 1 to 3 bytes; first byte lands in the top byte.
// - Write data is right-justified; unused top bits of first byte ignored.
// - Checksum restarts from the most significant read bit on the edge that drives it.
// - Each driven read bit is added to the checksum.
// - After a read the checksum holds the count of ones just read.
// - Reading the checksum register checksums the checksum value shifted out.
// - Command top bit 0 selects read; data driven from next rising edge.
// - Serial output released on the falling edge of the last read clock.
`timescale 1ns/1ps
`include "srpc_consts.svh"

module srpc_port #(
  parameter logic [5:0] CSUM_ADDR = `SRPC_CSUM_ADDR,
  parameter int         WORD_BITS = `SRPC_WORD_BITS
) (
  // System clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Serial link pins
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    din,
  output logic                         dout,
  output logic                         dout_oe,
  // Register lookup, combinational in reg_addr on the user side
  output logic [5:0]                   reg_addr,
  input  wire logic [1:0]              reg_bytes,
  input  wire logic [WORD_BITS-1:0]    rd_data,
  // Write bytes handed to the register file, system clock domain
  output logic                         wr_valid,
  output srpc_pkg::srpc_wbeat_type     wr_beat,
  // Chip select state seen in the system clock domain
  output logic                         sel_active
);

  if (WORD_BITS != `SRPC_WORD_BITS) begin : g_width_check
    $error("srpc_port serves only 24-bit register words");
  end

  // Link domain: cs_n high holds the shifter in reset, so both the
  // falling and the rising chip select edge act without a serial clock.
  logic                           link_rst;
  srpc_pkg::srpc_phase_type       phase_q;
  logic [4:0]                     cnt_q;
  logic [1:0]                     byte_q;
  logic [7:0]                     sh_q;
  logic [5:0]                     addr_q;
  logic [1:0]                     eff_bytes;
  logic [4:0]                     last_bit;
  logic [1:0]                     last_byte;
  logic [7:0]                     byte_in;
  logic [WORD_BITS-1:0]           rd_src;
  logic [WORD_BITS-1:0]           rd_aligned;
  logic [WORD_BITS-1:0]           out_sh_q;
  logic                           oe_q;
  logic [5:0]                     csum_q;
  srpc_pkg::srpc_wbeat_type       hold_q;
  logic                           tog_q;

  assign link_rst = sys_rst | cs_n;
  assign byte_in  = {sh_q[6:0], din};

  // The checksum register always reads as one byte; zero widths act as one.
  always_comb begin
    if (addr_q == CSUM_ADDR || reg_bytes == `SRPC_BYTE_ZERO) begin
      eff_bytes = `SRPC_BYTE_ONE;
    end else begin
      eff_bytes = reg_bytes;
    end
    last_byte = eff_bytes - `SRPC_BYTE_ONE;
    last_bit  = {eff_bytes, 3'h0} - `SRPC_CNT_ONE;
  end

  // Command, write and read sequencing on the falling serial clock edge.
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      phase_q <= srpc_pkg::PH_CMD;
      cnt_q   <= `SRPC_CNT_ZERO;
      byte_q  <= `SRPC_BYTE_ZERO;
      sh_q    <= 8'h00;
      addr_q  <= 6'h00;
    end else begin
      sh_q <= byte_in;
      case (phase_q)
        srpc_pkg::PH_CMD: begin
          if (cnt_q == `SRPC_CMD_LAST) begin
            addr_q <= byte_in[`SRPC_ADDR_MSB:0];
            cnt_q  <= `SRPC_CNT_ZERO;
            byte_q <= `SRPC_BYTE_ZERO;
            if (byte_in[`SRPC_DIR_BIT]) begin
              phase_q <= srpc_pkg::PH_WRITE;
            end else begin
              phase_q <= srpc_pkg::PH_READ;
            end
          end else begin
            cnt_q <= cnt_q + `SRPC_CNT_ONE;
          end
        end
        srpc_pkg::PH_WRITE: begin
          if (cnt_q[2:0] == `SRPC_BYTE_LAST) begin
            cnt_q <= `SRPC_CNT_ZERO;
            if (byte_q == last_byte) begin
              phase_q <= srpc_pkg::PH_CMD;
            end else begin
              byte_q <= byte_q + `SRPC_BYTE_ONE;
            end
          end else begin
            cnt_q <= cnt_q + `SRPC_CNT_ONE;
          end
        end
        srpc_pkg::PH_READ: begin
          if (cnt_q == last_bit) begin
            phase_q <= srpc_pkg::PH_CMD;
            cnt_q   <= `SRPC_CNT_ZERO;
          end else begin
            cnt_q <= cnt_q + `SRPC_CNT_ONE;
          end
        end
        default: begin
          phase_q <= srpc_pkg::PH_CMD;
        end
      endcase
    end
  end

  // Completed write bytes are parked and announced by a toggle. This sits
  // outside the chip select reset so an abort never fakes an event, and a
  // partial byte never reaches the hold register.
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= '0;
      tog_q  <= 1'b0;
    end else if (!cs_n && phase_q == srpc_pkg::PH_WRITE &&
                 cnt_q[2:0] == `SRPC_BYTE_LAST) begin
      hold_q.addr <= addr_q;
      hold_q.lane <= last_byte - byte_q;
      hold_q.data <= byte_in;
      tog_q       <= ~tog_q;
    end
  end

  assign rd_src = (addr_q == CSUM_ADDR) ? {18'h00000, csum_q} : rd_data;

  // Right-justified words are shifted out from their top used byte.
  always_comb begin
    case (eff_bytes)
      `SRPC_BYTE_ONE: rd_aligned = {rd_src[7:0], 16'h0000};
      `SRPC_BYTE_TWO: rd_aligned = {rd_src[15:0], 8'h00};
      default:        rd_aligned = rd_src;
    endcase
  end

  // Read shifter on the rising serial clock edge.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      out_sh_q <= '0;
      oe_q     <= 1'b0;
    end else if (phase_q == srpc_pkg::PH_READ) begin
      oe_q <= 1'b1;
      if (!oe_q) begin
        out_sh_q <= rd_aligned;
      end else begin
        out_sh_q <= {out_sh_q[WORD_BITS-2:0], 1'b0};
      end
    end else begin
      oe_q <= 1'b0;
    end
  end

  // The checksum survives chip select so the host may read it afterwards.
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      csum_q <= `SRPC_CSUM_ZERO;
    end else if (!cs_n && phase_q == srpc_pkg::PH_READ) begin
      if (!oe_q) begin
        csum_q <= {5'h00, rd_aligned[`SRPC_WORD_MSB]};
      end else begin
        csum_q <= csum_q + {5'h00, out_sh_q[`SRPC_WORD_MSB-1]};
      end
    end
  end

  assign dout     = out_sh_q[`SRPC_WORD_MSB];
  assign dout_oe  = oe_q && phase_q == srpc_pkg::PH_READ && !cs_n;
  assign reg_addr = addr_q;

  // System clock side: three-stage synchronisers, a change counts once
  // the second and third stages agree.
  logic [2:0]                     tog_s_q;
  logic [2:0]                     cs_s_q;
  logic                           tog_seen_q;
  logic                           tog_new;
  logic                           wr_valid_q;
  srpc_pkg::srpc_wbeat_type       wr_beat_q;
  logic                           sel_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_s_q <= 3'h0;
      cs_s_q  <= 3'h7;
    end else begin
      tog_s_q <= {tog_s_q[1:0], tog_q};
      cs_s_q  <= {cs_s_q[1:0], cs_n};
    end
  end

  assign tog_new = (tog_s_q[2] == tog_s_q[1]) && (tog_s_q[2] != tog_seen_q);

  // The hold register is stable for a full byte time after the toggle,
  // far longer than the synchroniser delay.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_seen_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_beat_q  <= '0;
    end else begin
      wr_valid_q <= tog_new;
      if (tog_new) begin
        tog_seen_q <= tog_s_q[2];
        wr_beat_q  <= hold_q;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= 1'b0;
    end else if (cs_s_q[2] == cs_s_q[1]) begin
      sel_q <= ~cs_s_q[2];
    end
  end

  assign wr_valid   = wr_valid_q;
  assign wr_beat    = wr_beat_q;
  assign sel_active = sel_q;

endmodule // srpc_port

/* verification/srpc_chk.sv */
// Concurrent checks on the serial register port pins and write strobes.
`timescale 1ns/1ps

module srpc_chk (
  // System side
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                wr_valid,
  input srpc_pkg::srpc_wbeat_type wr_beat,
  input wire logic                sel_active,
  input wire logic [5:0]          reg_addr,
  input wire logic [1:0]          reg_bytes,
  // Serial link
  input wire logic                sclk,
  input wire logic                cs_n,
  input wire logic                dout,
  input wire logic                dout_oe
);
  logic f_dout;
  logic f_oe;

  // Output as seen at each fall; a rise must still show it, so it only moves on rises.
  always_ff @(negedge sclk or posedge cs_n or posedge sys_rst) begin
    if (sys_rst || cs_n) begin
      f_dout <= 1'b0;
      f_oe   <= 1'b0;
    end else begin
      f_dout <= dout;
      f_oe   <= dout_oe;
    end
  end

  sequence s_wv_pulse;
    wr_valid ##1 !wr_valid;
  endsequence
  sequence s_byte_out;
    dout_oe [*7];
  endsequence

  property p_oe_cs;
    @(posedge clk) disable iff (sys_rst) cs_n |-> !dout_oe;
  endproperty
  property p_wv_pulse;
    @(posedge clk) disable iff (sys_rst) wr_valid |-> s_wv_pulse;
  endproperty
  property p_wv_addr;
    @(posedge clk) disable iff (sys_rst)
      wr_valid |-> wr_beat.addr == reg_addr && wr_beat.lane < reg_bytes;
  endproperty
  property p_sel_on;
    @(posedge clk) disable iff (sys_rst) $fell(cs_n) |-> ##[2:4] sel_active;
  endproperty
  property p_sel_off;
    @(posedge clk) disable iff (sys_rst) $rose(cs_n) |-> ##[2:4] !sel_active;
  endproperty
  property p_dout_hold;
    @(posedge sclk) disable iff (sys_rst || cs_n) f_oe |-> dout == f_dout;
  endproperty
  property p_rd_len;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      $rose(dout_oe) && reg_bytes == 2'h1 |-> s_byte_out ##1 !dout_oe;
  endproperty
  property p_addr;
    @(negedge sclk) disable iff (sys_rst || cs_n)
      dout_oe && $past(dout_oe) |-> $stable(reg_addr);
  endproperty

  a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
  a_wv_pulse: assert property (p_wv_pulse) else $error("write strobe too long");
  a_wv_addr: assert property (p_wv_addr) else $error("write beat address or lane");
  a_sel_on: assert property (p_sel_on) else $error("select not seen");
  a_sel_off: assert property (p_sel_off) else $error("deselect not seen");
  a_dout_hold: assert property (p_dout_hold) else $error("output moved on a fall");
  a_rd_len: assert property (p_rd_len) else $error("read length wrong");
  a_addr: assert property (p_addr) else $error("address moved in read");
endmodule // srpc_chk

bind srpc_port srpc_chk srpc_chk_i (.clk(clk), .sys_rst(sys_rst), .wr_valid(wr_valid),
  .wr_beat(wr_beat), .sel_active(sel_active), .reg_addr(reg_addr), .reg_bytes(reg_bytes),
  .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe));

/* verification/srpc_host.sv */
// Behavioural host that masters the serial link.
`timescale 1ns/1ps
`include "srpc_consts.svh"

module srpc_host (
  // Link lines driven by the host
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  // Resolved serial output of the port
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic sel();
    cs_n = 1'b0;
    #30;
  endtask

  // The data line is flipped on release so nobody can lean on a stale level.
  task automatic desel();
    cs_n = 1'b1;
    din  = ~din;
    #250;
  endtask

  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      #15 rx = {rx[6:0], sdo};
      sclk = 1'b0;
      #15;
    end
  endtask

  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [7:0] b;
    rd = 24'h0;
    shift({cmd[7], 1'b0, cmd[5:0]}, 8, b);
    for (int k = nb - 1; k >= 0; k--) begin
      shift(wd[8*k +: 8], 8, b);
      rd[8*k +: 8] = b;
      if (cmd[7]) #(`SRPC_BYTE_SPACING_NS);
    end
  endtask
endmodule // srpc_host

/* verification/serial_register_port_checksum_test.sv */
// Self-checking bench for the serial register port and read checksum.
`timescale 1ns/1ps

module serial_register_port_checksum_test;
  logic                     clk;
  logic                     sys_rst;
  logic [1:0]               reg_bytes;
  logic [23:0]              rd_data;
  logic [23:0]              mem [64];
  logic [15:0]              beats [$];
  logic [7:0]               b;
  srpc_pkg::srpc_wbeat_type wr_beat;
  wire                      sclk, cs_n, din, dout, dout_oe, wr_valid, sel_active;
  wire  [5:0]               reg_addr;
  wire                      sdo = dout_oe ? dout : 1'bz;
  int                       error_cnt;
  int                       num_checks;

  srpc_port srpc_port_i (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .reg_addr(reg_addr), .reg_bytes(reg_bytes),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_beat(wr_beat), .sel_active(sel_active));
  srpc_host srpc_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [1:0] nb(input logic [5:0] a);
    return (a == 6'h3f) ? 2'h1 : ((a[1:0] == 2'h0) ? 2'h3 : a[1:0]);
  endfunction
  function automatic logic [23:0] ones(input logic [23:0] v);
    return {18'h0, 6'($countones(v))};
  endfunction

  // Register file: address 2 is a 12-bit register, 3f is one byte; the others are as many bytes as their low two address bits, with 00 meaning three.
  always_comb reg_bytes = nb(reg_addr);
  always_comb rd_data = (reg_addr == 6'h02) ? {12'h000, mem[2][11:0]} : mem[reg_addr];
  initial for (int i = 0; i < 64; i++) mem[i] = 24'h0;
  always @(posedge clk) begin
    if (wr_valid) begin
      beats.push_back(wr_beat);
      mem[wr_beat.addr][8*wr_beat.lane +: 8] <= wr_beat.data;
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] junk;
    srpc_host_i.xfer({2'b10, a}, nb(a), d, junk);
    for (int k = nb(a) - 1; k >= 0; k--) begin
      chk({8'h00, beats.pop_front()}, {8'h00, a, k[1:0], d[8*k +: 8]});
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] got;
    srpc_host_i.xfer({2'b00, a}, nb(a), 24'h0, got);
    chk(got, e);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  initial begin
    error_cnt  = 0;
    num_checks = 0;
    sys_rst    = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk({15'h0, dout_oe, wr_valid, sel_active, reg_addr}, 24'h0);
    srpc_host_i.sel();
    wr(6'h04, 24'ha5c396);
    wr(6'h02, 24'h00fabc);
    wr(6'h01, 24'h000081);
    rd(6'h04, 24'ha5c396);
    rd(6'h3f, ones(24'ha5c396));
    rd(6'h3f, ones(ones(24'ha5c396)));
    rd(6'h02, 24'h000abc);
    rd(6'h3f, ones(24'h000abc));
    srpc_host_i.desel();
    srpc_host_i.sel();
    srpc_host_i.shift({2'b10, 6'h01}, 8, b);
    srpc_host_i.shift(8'hff, 4, b);
    srpc_host_i.desel();
    srpc_host_i.sel();
    rd(6'h01, 24'h000081);
    chk({8'h00, 16'(beats.size())}, 24'h0);
    srpc_host_i.shift({2'b00, 6'h04}, 8, b);
    srpc_host_i.shift(8'h00, 3, b);
    srpc_host_i.desel();
    chk({23'h0, dout_oe}, 24'h0);
    srpc_host_i.sel();
    srpc_host_i.shift({2'b00, 6'h04}, 5, b);
    @(negedge clk) sys_rst = 1'b1;
    @(negedge clk) sys_rst = 1'b0;
    rd(6'h3f, 24'h0);
    rd(6'h01, 24'h000081);
    srpc_host_i.desel();
    test_done();
  end
endmodule // serial_register_port_checksum_test
